// file: core/cirq_ladder.sv
// Purpose: reference ladder level, in 96ths of the supply
// Assumes: tap and range come from the reference control register
// Notes: level is zero while the ladder is powered down
`timescale 1ns/1ps
module cirq_ladder
    import cirq_pkg::*;
(
    // control
    input wire logic power_on,
    input wire logic low_range,
    input wire logic [TAP_W-1:0] tap,
    // level as a fraction of the supply: numerator over 96
    output logic [7:0] level_96
);
    // 96 is the common multiple of 32 and 24, so both ranges stay exact
    always_comb begin
        level_96 = 8'h00;
        if (power_on) begin
            if (low_range) begin
                level_96 = 8'({4'h0, tap} * 8'h04);
            end else begin
                level_96 = 8'((HIGH_BASE_32 + {4'h0, tap}) * 8'h03);
            end
        end
    end
endmodule : cirq_ladder

// file: core/cirq_pkg.sv
// Purpose: constants for the comparator interrupt and reference control block
// Assumes: 32-bit classic wishbone, byte addresses, 8-bit registers in low bits
// Notes: register map and field positions used by cirq_top and cirq_ladder
package cirq_pkg;
    // ********************************************************************
    // register offsets (byte addresses)
    // ********************************************************************
    localparam logic [7:0] OFF_CMP_CTRL = 8'h00;
    localparam logic [7:0] OFF_PERIPH_FLAG = 8'h04;
    localparam logic [7:0] OFF_PERIPH_EN = 8'h08;
    localparam logic [7:0] OFF_IRQ_CTRL = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_SLEEP = 8'h18;
    // reference control index as printed; byte address is four times it
    localparam logic [7:0] IDX_REF_CTRL = 8'h9f;
    localparam logic [9:0] OFF_REF_CTRL = {IDX_REF_CTRL, 2'b00};
    localparam int ADDR_W = 10;
    // ********************************************************************
    // field positions
    // ********************************************************************
    localparam int BIT_CMP_FLAG = 6;
    localparam int BIT_CMP_EN = 6;
    localparam int BIT_PERIPH_EN = 6;
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_CMP_ONE = 6;
    localparam int BIT_CMP_TWO = 7;
    localparam int BIT_REF_PWR = 7;
    localparam int BIT_REF_OE = 6;
    localparam int BIT_REF_LOW = 5;
    localparam int TAP_W = 4;
    localparam int MODE_W = 3;
    // ********************************************************************
    // reset values and masks
    // ********************************************************************
    localparam logic [7:0] CMP_CTRL_RST = 8'h00;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [2:0] MODE_OFF = 3'h7;
    localparam logic [7:0] REF_CTRL_RST = 8'h00;
    localparam logic [7:0] REF_CTRL_MASK = 8'hef;
    localparam logic [7:0] CMP_CTRL_WMASK = 8'h3f;
    localparam logic [1:0] STAT_CHANGE = 2'h1;
    localparam logic [1:0] STAT_WAKE = 2'h2;
    // ladder: high range quarter offset is 8/32, low range divides by 24
    localparam logic [7:0] HIGH_BASE_32 = 8'h08;
    localparam logic [7:0] HIGH_DIV = 8'h20;
    localparam logic [7:0] LOW_DIV = 8'h18;
    // ********************************************************************
    // bus cycle state
    // ********************************************************************
    typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} cirq_bus_type;
endpackage : cirq_pkg

// file: core/cirq_sync.sv
// Purpose: two flip-flop synchroniser for the comparator outputs
// Assumes: input is asynchronous to CLOCK
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module cirq_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] out_d;

    always_comb begin
        meta_d = din;
        out_d = meta_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            out_q <= '0;
        end else begin
            meta_q <= meta_d;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule : cirq_sync

// file: core/cirq_top.sv
// Purpose: comparator change interrupt and reference ladder control
// Assumes: classic wishbone slave, one clock at 250 MHz, async reset high
// Notes: comparator mode decoding is outside this block, except mode 111, which this block decodes to power the comparators off
//
// Contract
// - Change flag sets whenever either comparator output changes.
// - Change flag is bit 6 of flag register; write zero clears, one sets.
// - Interrupt reaches core only with comparator, peripheral and global enables; IRQ takes the change event gated by mask bit 0 alone.
// - Mismatch keeps setting flag; any comparator control access ends it.
// - Change coinciding with control register read may fail to set flag.
// - Comparator outputs read back on control register bits 7 and 6.
// - In sleep the comparator runs and its enabled interrupt wakes device.
// - Comparator control register is unchanged on wake from sleep.
// - Reset returns control register to mode 000; comparators are powered down while reset holds, and after it only in mode 111.
// - Reference bit 7 powers the ladder on; zero powers it down.
// - Reference bit 6 connects the ladder output to its pin.
// - Reference bit 5 selects low range when one, high when zero.
// - Four-bit tap in bits 3..0 selects one of 16 levels.
// - High range level is supply/4 plus tap/32 of supply.
// - Global interrupt enable is bit 7 of interrupt control register.
`timescale 1ns/1ps
module cirq_top
    import cirq_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ADDR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // comparator outputs from the analog side
    input wire logic CMP_ONE_OUTPUT,
    input wire logic CMP_TWO_OUTPUT,
    // comparator control
    output logic [MODE_W-1:0] CMP_MODE_FIELD,
    output logic CMP_POWER_ON,
    // reference ladder control
    output logic REF_POWER_ENABLE,
    output logic REF_PIN_OUTPUT_ENABLE,
    output logic REF_LOW_RANGE,
    output logic [TAP_W-1:0] REF_TAP_SELECT,
    output logic [7:0] REF_LEVEL_96,
    // interrupt and wake
    output logic CMP_IRQ,
    output logic WAKE_REQ,
    output logic IRQ
);
    // ********************************************************************
    // synchronised comparator outputs
    // ********************************************************************
    logic [1:0] live_cmp;

    cirq_sync #(.WIDTH(2)) u_sync (
        .clk(CLOCK),
        .rst(SYS_RST),
        .din({CMP_TWO_OUTPUT, CMP_ONE_OUTPUT}),
        .dout(live_cmp)
    );

    // ********************************************************************
    // state
    // ********************************************************************
    cirq_bus_type bus_q, bus_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] cmp_ctrl_q, cmp_ctrl_d;
    logic [1:0] seen_q, seen_d;
    logic cmp_change_flag_q, cmp_change_flag_d;
    logic cmp_irq_enable_q, cmp_irq_enable_d;
    logic periph_irq_enable_q, periph_irq_enable_d;
    logic global_irq_enable_q, global_irq_enable_d;
    logic [1:0] stat_q, stat_d;
    logic [1:0] mask_q, mask_d;
    logic sleep_q, sleep_d;
    logic [7:0] ref_ctrl_q, ref_ctrl_d;
    logic cmp_irq_q, cmp_irq_d;
    logic wake_q, wake_d;
    logic irq_q, irq_d;
    logic [7:0] level_q, level_d;

    logic req;
    logic wr_en;
    logic rd_en;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wbyte;
    logic mismatch;
    logic cmp_access;
    logic [7:0] level_w;
    logic [7:0] cmp_rd;

    // ********************************************************************
    // bus decode
    // ********************************************************************
    // one request per cycle: ack comes the cycle after the strobe is seen
    // only byte lane 0 carries data; a write without it changes no register, but still counts as a comparator control access
    always_comb begin
        req = WB_CYC_I && WB_STB_I && (bus_q == BUS_IDLE);
        wr_en = req && WB_WE_I && WB_SEL_I[0];
        rd_en = req && !WB_WE_I;
        addr = WB_ADR_I;
        wbyte = WB_DAT_I[7:0];
        cmp_access = req && (addr == ADDR_W'(OFF_CMP_CTRL));
        mismatch = (live_cmp != seen_q);
        cmp_rd = cmp_ctrl_q & CMP_CTRL_WMASK;
        cmp_rd[BIT_CMP_TWO] = live_cmp[1];
        cmp_rd[BIT_CMP_ONE] = live_cmp[0];
    end

    cirq_ladder u_ladder (
        .power_on(ref_ctrl_q[BIT_REF_PWR]),
        .low_range(ref_ctrl_q[BIT_REF_LOW]),
        .tap(ref_ctrl_q[TAP_W-1:0]),
        .level_96(level_w)
    );

    // ********************************************************************
    // next state
    // ********************************************************************
    always_comb begin
        bus_d = BUS_IDLE;
        rdata_d = rdata_q;
        cmp_ctrl_d = cmp_ctrl_q;
        seen_d = seen_q;
        cmp_change_flag_d = cmp_change_flag_q;
        cmp_irq_enable_d = cmp_irq_enable_q;
        periph_irq_enable_d = periph_irq_enable_q;
        global_irq_enable_d = global_irq_enable_q;
        stat_d = stat_q;
        mask_d = mask_q;
        sleep_d = sleep_q;
        ref_ctrl_d = ref_ctrl_q;
        if (req) begin
            bus_d = BUS_ACK;
            rdata_d = 32'h0;
            if (wr_en) begin
                case (addr)
                    ADDR_W'(OFF_CMP_CTRL): begin
                        cmp_ctrl_d = wbyte & CMP_CTRL_WMASK;
                    end
                    ADDR_W'(OFF_PERIPH_FLAG): begin
                        cmp_change_flag_d = wbyte[BIT_CMP_FLAG];
                    end
                    ADDR_W'(OFF_PERIPH_EN): begin
                        cmp_irq_enable_d = wbyte[BIT_CMP_EN];
                    end
                    ADDR_W'(OFF_IRQ_CTRL): begin
                        periph_irq_enable_d = wbyte[BIT_PERIPH_EN];
                        global_irq_enable_d = wbyte[BIT_GLOBAL_EN];
                    end
                    ADDR_W'(OFF_IRQ_MASK): begin
                        mask_d = wbyte[1:0];
                    end
                    ADDR_W'(OFF_SLEEP): begin
                        sleep_d = wbyte[0];
                    end
                    OFF_REF_CTRL: begin
                        ref_ctrl_d = wbyte & REF_CTRL_MASK;
                    end
                    default: begin
                    end
                endcase
            end else if (rd_en) begin
                case (addr)
                    ADDR_W'(OFF_CMP_CTRL): rdata_d = {24'h0, cmp_rd};
                    ADDR_W'(OFF_PERIPH_FLAG): begin
                        rdata_d[BIT_CMP_FLAG] = cmp_change_flag_q;
                    end
                    ADDR_W'(OFF_PERIPH_EN): begin
                        rdata_d[BIT_CMP_EN] = cmp_irq_enable_q;
                    end
                    ADDR_W'(OFF_IRQ_CTRL): begin
                        rdata_d[BIT_GLOBAL_EN] = global_irq_enable_q;
                        rdata_d[BIT_PERIPH_EN] = periph_irq_enable_q;
                    end
                    ADDR_W'(OFF_IRQ_STAT): begin
                        rdata_d = {30'h0, stat_q};
                        stat_d = 2'h0;
                    end
                    ADDR_W'(OFF_IRQ_MASK): rdata_d = {30'h0, mask_q};
                    ADDR_W'(OFF_SLEEP): rdata_d = {31'h0, sleep_q};
                    OFF_REF_CTRL: rdata_d = {24'h0, ref_ctrl_q};
                    default: rdata_d = 32'h0;
                endcase
            end
        end
        // ****************************************************************
        // change detect and events
        // ****************************************************************
        // access records what software saw; a change in that same cycle
        // is absorbed into the snapshot and raises no flag
        if (cmp_access) begin
            seen_d = live_cmp;
        end else if (mismatch) begin
            cmp_change_flag_d = 1'b1;
        end
        // hardware events win over the status clear-on-read
        if (mismatch && !cmp_access) begin
            stat_d = stat_d | STAT_CHANGE;
        end
        // the wake event is logged without the global enable, as wake ignores it
        if (wake_d) begin
            stat_d = stat_d | STAT_WAKE;
        end
        // wake leaves comparator control untouched; only sleep ends
        if (wake_d) begin
            sleep_d = 1'b0;
        end
    end

    // ********************************************************************
    // outputs
    // ********************************************************************
    always_comb begin
        cmp_irq_d = cmp_change_flag_q && cmp_irq_enable_q
            && periph_irq_enable_q && global_irq_enable_q;
        // wake needs only the comparator and peripheral enables, not the global one, as in sleep the core halts
        wake_d = sleep_q && cmp_change_flag_q && cmp_irq_enable_q
            && periph_irq_enable_q;
        // status and mask share one layout: bit 0 change, bit 1 wake
        irq_d = |(stat_q & mask_q);
        level_d = level_w;
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bus_q <= BUS_IDLE;
            rdata_q <= 32'h0;
            cmp_ctrl_q <= CMP_CTRL_RST;
            seen_q <= 2'h0;
            cmp_change_flag_q <= 1'b0;
            cmp_irq_enable_q <= 1'b0;
            periph_irq_enable_q <= 1'b0;
            global_irq_enable_q <= 1'b0;
            stat_q <= 2'h0;
            mask_q <= 2'h0;
            sleep_q <= 1'b0;
            ref_ctrl_q <= REF_CTRL_RST;
            cmp_irq_q <= 1'b0;
            wake_q <= 1'b0;
            irq_q <= 1'b0;
            level_q <= 8'h00;
        end else begin
            bus_q <= bus_d;
            rdata_q <= rdata_d;
            cmp_ctrl_q <= cmp_ctrl_d;
            seen_q <= seen_d;
            cmp_change_flag_q <= cmp_change_flag_d;
            cmp_irq_enable_q <= cmp_irq_enable_d;
            periph_irq_enable_q <= periph_irq_enable_d;
            global_irq_enable_q <= global_irq_enable_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            sleep_q <= sleep_d;
            ref_ctrl_q <= ref_ctrl_d;
            cmp_irq_q <= cmp_irq_d;
            wake_q <= wake_d;
            irq_q <= irq_d;
            level_q <= level_d;
        end
    end

    // ********************************************************************
    // comparator power
    // ********************************************************************
    // powered down while reset holds, since the flop clears asynchronously
    logic cmp_pwr_q, cmp_pwr_d;
    always_comb begin
        // mode 111 is the only setting that turns both comparators off
        cmp_pwr_d = (cmp_ctrl_q[MODE_W-1:0] != MODE_OFF);
    end
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cmp_pwr_q <= 1'b0;
        end else begin
            cmp_pwr_q <= cmp_pwr_d;
        end
    end

    // ********************************************************************
    // port drive
    // ********************************************************************
    assign WB_ACK_O = (bus_q == BUS_ACK);
    assign WB_DAT_O = rdata_q;
    assign CMP_MODE_FIELD = cmp_ctrl_q[MODE_W-1:0];
    assign CMP_POWER_ON = cmp_pwr_q;
    assign REF_POWER_ENABLE = ref_ctrl_q[BIT_REF_PWR];
    assign REF_PIN_OUTPUT_ENABLE = ref_ctrl_q[BIT_REF_OE];
    assign REF_LOW_RANGE = ref_ctrl_q[BIT_REF_LOW];
    assign REF_TAP_SELECT = ref_ctrl_q[TAP_W-1:0];
    assign REF_LEVEL_96 = level_q;
    assign CMP_IRQ = cmp_irq_q;
    // wake is a one-cycle pulse, since sleep clears as it fires
    assign WAKE_REQ = wake_q;
    assign IRQ = irq_q;
endmodule : cirq_top

// file: test/cirq_core_model.sv
// Purpose: processor core model issuing classic wishbone cycles
// Assumes: called right after a rising edge
// Notes: waits for ack however long; the bench watchdog ends a hang
`timescale 1ns/1ps
module cirq_core
    import cirq_pkg::*;
(
    // clock and answer
    input wire logic clk,
    input wire logic ack,
    input wire logic [31:0] rdat,
    // request
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [ADDR_W-1:0] adr,
    output logic [3:0] sel,
    output logic [31:0] wdat
);
    initial {cyc, stb, we, adr, sel, wdat} = '0;
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [7:0] d, output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        {cyc, stb, we} <= 3'h0;
        // released data must not keep looking valid
        wdat <= ~wdat;
        @(posedge clk);
    endtask : xfer
endmodule : cirq_core

// file: test/cirq_properties.sv
// Purpose: port-level properties of the comparator interrupt block
// Assumes: one clock, reset high
// Notes: bound into cirq_top
`timescale 1ns/1ps
module cirq_props
    import cirq_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ADDR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // comparators
    input wire logic CMP_ONE_OUTPUT,
    input wire logic CMP_TWO_OUTPUT,
    // reference
    input wire logic REF_POWER_ENABLE,
    input wire logic REF_PIN_OUTPUT_ENABLE,
    input wire logic REF_LOW_RANGE,
    input wire logic [TAP_W-1:0] REF_TAP_SELECT,
    input wire logic [7:0] REF_LEVEL_96
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);
    logic take;
    assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    sequence s_wr_ref;
        take && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == OFF_REF_CTRL;
    endsequence
    sequence s_rd_cmp;
        take && !WB_WE_I && WB_ADR_I == 10'(OFF_CMP_CTRL);
    endsequence
    // synchroniser needs the inputs quiet for a few edges
    sequence s_steady;
        ($stable(CMP_ONE_OUTPUT) && $stable(CMP_TWO_OUTPUT))[*4];
    endsequence
    property p_ref_pwr;
        s_wr_ref |=> REF_POWER_ENABLE == $past(WB_DAT_I[BIT_REF_PWR]);
    endproperty
    a_ref_pwr: assert property (p_ref_pwr) else $error("ladder power bit wrong");
    property p_ref_oe;
        s_wr_ref |=> REF_PIN_OUTPUT_ENABLE == $past(WB_DAT_I[BIT_REF_OE]);
    endproperty
    a_ref_oe: assert property (p_ref_oe) else $error("pin output bit wrong");
    property p_ref_low;
        s_wr_ref |=> REF_LOW_RANGE == $past(WB_DAT_I[BIT_REF_LOW]);
    endproperty
    a_ref_low: assert property (p_ref_low) else $error("range bit wrong");
    property p_ref_tap;
        s_wr_ref |=> REF_TAP_SELECT == $past(WB_DAT_I[3:0]);
    endproperty
    a_ref_tap: assert property (p_ref_tap) else $error("tap field wrong");
    property p_lvl_high;
        REF_POWER_ENABLE && !REF_LOW_RANGE |=>
            REF_LEVEL_96 == 8'h18 + 8'h03 * $past(REF_TAP_SELECT);
    endproperty
    a_lvl_high: assert property (p_lvl_high) else $error("high range level wrong");
    property p_lvl_low;
        REF_POWER_ENABLE && REF_LOW_RANGE |=> REF_LEVEL_96 == 8'h04 * $past(REF_TAP_SELECT);
    endproperty
    a_lvl_low: assert property (p_lvl_low) else $error("low range level wrong");
    property p_lvl_off;
        !REF_POWER_ENABLE |=> REF_LEVEL_96 == 8'h00;
    endproperty
    a_lvl_off: assert property (p_lvl_off) else $error("level while powered down");
    property p_rd_ref;
        take && !WB_WE_I && WB_ADR_I == OFF_REF_CTRL |=> WB_DAT_O[7:0] ==
            {REF_POWER_ENABLE, REF_PIN_OUTPUT_ENABLE, REF_LOW_RANGE, 1'b0, REF_TAP_SELECT};
    endproperty
    a_rd_ref: assert property (p_rd_ref) else $error("reference read wrong");
    property p_readback;
        s_steady ##0 s_rd_cmp |=>
            WB_DAT_O[7:6] == {$past(CMP_TWO_OUTPUT), $past(CMP_ONE_OUTPUT)};
    endproperty
    a_readback: assert property (p_readback) else $error("live bits wrong");
endmodule : cirq_props

bind cirq_top cirq_props u_props (
    .CLOCK, .SYS_RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I,
    .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .CMP_ONE_OUTPUT, .CMP_TWO_OUTPUT,
    .REF_POWER_ENABLE, .REF_PIN_OUTPUT_ENABLE, .REF_LOW_RANGE, .REF_TAP_SELECT,
    .REF_LEVEL_96
);

// file: test/testbench.sv
// Purpose: self-checking bench for comparator interrupt and reference
// Assumes: core model does the bus cycles
// Notes: expectations come from the register layout only
`timescale 1ns/1ps
module testbench
    import cirq_pkg::*;
;
    logic CLOCK, SYS_RST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
    logic [ADDR_W-1:0] WB_ADR_I;
    logic [3:0] WB_SEL_I, REF_TAP_SELECT;
    logic [31:0] WB_DAT_I, WB_DAT_O, q;
    logic CMP_ONE_OUTPUT, CMP_TWO_OUTPUT, CMP_POWER_ON, REF_POWER_ENABLE;
    logic REF_PIN_OUTPUT_ENABLE, REF_LOW_RANGE, CMP_IRQ, WAKE_REQ, IRQ;
    logic [2:0] CMP_MODE_FIELD;
    logic [7:0] REF_LEVEL_96, v, lv;
    int n_mismatch = 0;
    int n_checks = 0;
    int n;
    cirq_top u_dut (.CLOCK, .SYS_RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
        .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .CMP_ONE_OUTPUT, .CMP_TWO_OUTPUT,
        .CMP_MODE_FIELD, .CMP_POWER_ON, .REF_POWER_ENABLE, .REF_PIN_OUTPUT_ENABLE,
        .REF_LOW_RANGE, .REF_TAP_SELECT, .REF_LEVEL_96, .CMP_IRQ, .WAKE_REQ, .IRQ);
    cirq_core u_core (.clk(CLOCK), .ack(WB_ACK_O), .rdat(WB_DAT_O), .cyc(WB_CYC_I),
        .stb(WB_STB_I), .we(WB_WE_I), .adr(WB_ADR_I), .sel(WB_SEL_I), .wdat(WB_DAT_I));
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        u_core.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        u_core.xfer(1'b0, a, 8'h00, q);
        chk(q, {24'h0, e});
    endtask : rd
    task automatic tick(input int c);
        repeat (c) @(posedge CLOCK);
    endtask : tick
    task automatic do_reset();
        SYS_RST <= 1'b1;
        tick(16);
        chk(CMP_POWER_ON, 32'h0);
        chk(CMP_MODE_FIELD, 32'h0);
        SYS_RST <= 1'b0;
        tick(1);
    endtask : do_reset
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    // ****************************************************************
    // clock, watchdog, tests
    // ****************************************************************
    initial begin
        CLOCK = 1'b0;
        forever #2 CLOCK = ~CLOCK;
    end
    initial begin
        tick(10000);
        n_mismatch++;
        stop_test();
    end
    initial begin
        CMP_ONE_OUTPUT <= 1'b0;
        CMP_TWO_OUTPUT <= 1'b0;
        do_reset();
        rd(OFF_CMP_CTRL, 8'h00);
        rd(OFF_REF_CTRL, 8'h00);
        // bit 4 written as one to see it read back zero
        for (int i = 0; i < 48; i++) begin
            v = {i < 32, i[0], i[4], 1'b1, i[3:0]};
            wr(OFF_REF_CTRL, v); // read below gives settling time
            rd(OFF_REF_CTRL, v & REF_CTRL_MASK);
            chk(REF_POWER_ENABLE, v[7]);
            chk(REF_PIN_OUTPUT_ENABLE, v[6]);
            chk(REF_LOW_RANGE, v[5]);
            chk(REF_TAP_SELECT, v[3:0]);
            lv = v[5] ? {2'b00, v[3:0], 2'b00} : 8'h18 + 8'h03 * v[3:0];
            chk(REF_LEVEL_96, v[7] ? lv : 8'h00);
        end
        wr(10'h3f0, 8'hff);
        rd(10'h3f0, 8'h00); // unmapped place reads zero
        rd(OFF_PERIPH_FLAG, 8'h00);
        CMP_ONE_OUTPUT <= 1'b1;
        tick(6);
        rd(OFF_PERIPH_FLAG, 8'h40);
        chk(CMP_IRQ, 32'h0);
        wr(OFF_PERIPH_FLAG, 8'h00);
        rd(OFF_PERIPH_FLAG, 8'h40);
        rd(OFF_CMP_CTRL, 8'h40);
        wr(OFF_PERIPH_FLAG, 8'h00);
        rd(OFF_PERIPH_FLAG, 8'h00);
        wr(OFF_PERIPH_FLAG, 8'hff);
        rd(OFF_PERIPH_FLAG, 8'h40);
        for (int i = 0; i < 8; i++) begin
            wr(OFF_PERIPH_EN, {1'b0, i[0], 6'h0});
            wr(OFF_IRQ_CTRL, {i[2], i[1], 6'h0});
            tick(2);
            chk(CMP_IRQ, i == 7);
        end
        CMP_TWO_OUTPUT <= 1'b1;
        tick(6);
        rd(OFF_CMP_CTRL, 8'hc0);
        wr(OFF_PERIPH_FLAG, 8'h00);
        tick(2);
        chk(CMP_IRQ, 32'h0);
        // sticky events: read clears, mask gates the line
        rd(OFF_IRQ_STAT, 8'h01);
        rd(OFF_IRQ_STAT, 8'h00);
        wr(OFF_IRQ_MASK, 8'h00);
        CMP_ONE_OUTPUT <= 1'b0;
        tick(6);
        chk(IRQ, 32'h0);
        wr(OFF_IRQ_MASK, 8'h01);
        tick(2);
        chk(IRQ, 32'h1);
        rd(OFF_CMP_CTRL, 8'h80);
        rd(OFF_IRQ_STAT, 8'h01);
        tick(2);
        chk(IRQ, 32'h0);
        // wake does not need the global enable
        wr(OFF_IRQ_CTRL, 8'h40);
        wr(OFF_CMP_CTRL, 8'h05);
        wr(OFF_PERIPH_FLAG, 8'h00);
        wr(OFF_SLEEP, 8'h01);
        CMP_ONE_OUTPUT <= 1'b1;
        n = 0;
        while (WAKE_REQ !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        chk(WAKE_REQ, 32'h1);
        chk(CMP_IRQ, 32'h0);
        rd(OFF_CMP_CTRL, 8'hc5);
        chk(CMP_MODE_FIELD, 32'h5);
        rd(OFF_SLEEP, 8'h00);
        rd(OFF_IRQ_STAT, 8'h03);
        wr(OFF_CMP_CTRL, 8'h07); // comparators off before reset
        chk(CMP_POWER_ON, 32'h0);
        do_reset();
        tick(2);
        rd(OFF_REF_CTRL, 8'h00);
        rd(OFF_CMP_CTRL, 8'hc0);
        stop_test();
    end
endmodule : testbench
